// ### sprc_ctrl.sv
// Sleep mode control, brownout sleep unlock, peripheral clock stops and
// reset sequencing with a time-out delay counter.
// Assumes the core gives one-cycle sleep and wake pulses on clk_in, fuses are
// static, and the reset pin and supply monitors are asynchronous levels.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Sleep control bits 7:4 read zero.
// - Three mode bits select six sleep modes.
// - Standby codes need crystal; oscillator keeps running.
// - Sleep only when sleep gate bit set.
// - Off bit set only by timed unlock.
// - Effective off bit disables detector during sleep in modes other than idle and noise reduction.
// - Off bit effective two cycles after set.
// - Off bit clears itself after three cycles.
// - Clock stop bits stop module clocks.
// - Stopped module frozen, its registers blocked.
// - Timer2 stop only when synchronous.
// - Timer0 and timer1 stop bits halt timers.
// - Power reduction bit 4 reads zero.
// - Converter stop blocks comparator multiplexer use.
// - Reset loads initial values, then vector.
// - Port reset immediate, needs no clock.
// - Delay counter stretches reset after release.
// - Four sources combine into internal reset.
// - Supply detector reasserts reset without delay.
// - Reset pin works clockless; time-out follows only once the pin is seen low for SPRC_EXT_MIN_CYCLES clocks.
// - Disable fuse ignores reset pin.
module sprc_ctrl
	import sprc_pkg::*;
#(
	parameter int unsigned TOUT_MID_CYCLES  = SPRC_TOUT_MID_US * SPRC_CLK_MHZ,
	parameter int unsigned TOUT_LONG_CYCLES = SPRC_TOUT_LONG_US * SPRC_CLK_MHZ
) (
	input  wire logic        clk_in,                      // System clock.
	input  wire logic        srst_in,                     // Synchronous reset.
	input  wire logic [7:0]  addr_in,                     // Register address.
	input  wire logic [7:0]  wdata_in,                    // Write data.
	input  wire logic        wr_in,                       // Write strobe.
	input  wire logic        rd_in,                       // Read strobe.
	output logic      [7:0]  rdata_out,                   // Read data.
	input  wire logic        sleep_instr_in,              // Sleep instruction pulse.
	input  wire logic        wake_in,                     // Wake-up pulse.
	input  wire logic        timer2_async_select_in,      // Timer2 asynchronous.
	input  wire logic [3:0]  clock_select_fuse_in,        // Clock select fuses.
	input  wire logic [1:0]  startup_time_fuse_in,        // Start-up time fuses.
	input  wire logic        reset_pin_disable_fuse_in,   // Reset pin disabled.
	input  wire logic        bod_enable_fuse_in,          // Detector enabled.
	input  wire logic        por_low_in,                  // Supply below power-on level.
	input  wire logic        ext_reset_n_in,              // External reset pin.
	input  wire logic        wdt_reset_in,                // Watchdog reset pulse.
	input  wire logic        bod_low_in,                  // Supply below brownout level.
	output logic             sleep_active_out,            // Core is asleep.
	output logic      [2:0]  sleep_mode_out,              // Mode in force.
	output logic             bod_sleep_off_out,           // Detector turned off.
	output logic             osc_keep_out,                // Oscillator kept running.
	output logic      [7:0]  periph_clk_enable_out,       // Per-module clock enable.
	output logic      [7:0]  periph_io_block_out,         // Per-module register block.
	output logic             comparator_mux_allow_out,    // Comparator may use mux.
	output logic             port_reset_out,              // Immediate port reset.
	output logic             core_reset_out,              // Stretched internal reset.
	output logic             vector_load_out              // Start at reset vector.
);

	// All state of the block.
	typedef struct packed {
		logic [3:0]  sleep_ctrl;   // Mode select and sleep gate bit.
		logic [7:0]  power_red;    // Clock stop bits.
		logic        off_bit;      // Brownout sleep off bit.
		logic        unlock_bit;   // Brownout sleep unlock bit.
		logic [2:0]  unlock_cnt;   // Cycles left in the unlock window.
		logic [1:0]  off_age;      // Cycles since the off bit was set.
		sprc_sleep_t sleep_st;     // Sleep state.
		logic [2:0]  sleep_mode;   // Mode entered.
		logic        bod_off;      // Detector off for this sleep.
		logic        osc_keep;     // Oscillator kept for this sleep.
		sprc_rst_t   rst_st;       // Reset sequencer state.
		logic [21:0] tout_cnt;     // Time-out down counter.
		logic        vector_load;  // One-cycle start pulse.
		logic [7:0]  rdata;        // Registered read data.
		logic [1:0]  por_sync;     // Power-on level synchroniser.
		logic [1:0]  bod_sync;     // Brownout level synchroniser.
		logic [1:0]  ext_sync;     // Reset pin synchroniser.
		logic [6:0]  ext_low_cnt;  // Low time on the reset pin.
		logic        ext_trip;     // Pin has been low long enough.
	} sprc_state_t;

	// Value of the state after reset.
	localparam sprc_state_t SPRC_INIT = '{
		sleep_ctrl:  SPRC_SLEEP_CTRL_RESET,
		power_red:   SPRC_POWER_RED_RESET,
		off_bit:     1'b0,
		unlock_bit:  1'b0,
		unlock_cnt:  3'h0,
		off_age:     2'h0,
		sleep_st:    SPRC_AWAKE,
		sleep_mode:  3'h0,
		bod_off:     1'b0,
		osc_keep:    1'b0,
		rst_st:      SPRC_RST_HOLD,
		tout_cnt:    22'h0,
		vector_load: 1'b0,
		rdata:       8'h00,
		por_sync:    2'h0,
		bod_sync:    2'h0,
		ext_sync:    2'h3,
		ext_low_cnt: 7'h0,
		ext_trip:    1'b0
	};

	sprc_state_t s;            // Registered state.
	sprc_state_t next_s;       // Next state.
	logic [7:0]  stop_eff;     // Clock stop bits in force.
	logic        src_raw;      // Any source, straight from the inputs.
	logic        src_sync;     // Any source, seen on the clock.
	logic        off_active;   // Off bit effective this cycle.
	logic        crystal;      // Crystal or resonator clock option.
	logic [21:0] tout_sel;     // Time-out length less one.
	logic        mode_rsvd;    // Mode select holds a reserved code.
	logic [2:0]  mode_eff;     // Mode to enter.
	logic        mode_deep;    // Mode where the detector may be turned off.

	// Clock stop bits; timer2 honours its bit only in synchronous mode.
	for (genvar i = 0; i < 8; i++) begin : g_stop
		if (i == SPRC_TIM2_BIT) begin : g_tim2
			assign stop_eff[i] = s.power_red[i] & ~timer2_async_select_in;
		end else begin : g_plain
			assign stop_eff[i] = s.power_red[i];
		end
	end

	// Immediate source combination; needs no clock, so ports reset at once.
	always_comb begin
		src_raw = por_low_in
			| (~ext_reset_n_in & ~reset_pin_disable_fuse_in)
			| wdt_reset_in
			| (bod_low_in & bod_enable_fuse_in & ~s.bod_off);
	end

	// Source combination on the clock; the pin must stay low long enough.
	always_comb begin
		src_sync = s.por_sync[1]
			| s.ext_trip
			| wdt_reset_in
			| (s.bod_sync[1] & bod_enable_fuse_in & ~s.bod_off);
	end

	// Decode of fuses and mode select.
	always_comb begin
		crystal   = clock_select_fuse_in[3];
		off_active = s.off_bit & (s.off_age == SPRC_OFF_ACTIVE_AGE);
		// Time-out length from start-up and clock select fuses.
		if (clock_select_fuse_in == 4'h0) begin
			tout_sel = SPRC_TOUT_SHORT_CYCLES - 22'h1;
		end else begin
			unique case (startup_time_fuse_in)
				2'h0: tout_sel = SPRC_TOUT_SHORT_CYCLES - 22'h1;
				2'h1: tout_sel = 22'(TOUT_MID_CYCLES - 1);
				default: tout_sel = 22'(TOUT_LONG_CYCLES - 1);
			endcase
		end
		mode_rsvd = (s.sleep_ctrl[SPRC_SM_MSB:SPRC_SM_LSB] == SPRC_MODE_RSVD_A)
			| (s.sleep_ctrl[SPRC_SM_MSB:SPRC_SM_LSB] == SPRC_MODE_RSVD_B);
		// Standby codes fall back to their base modes without a crystal.
		unique case (s.sleep_ctrl[SPRC_SM_MSB:SPRC_SM_LSB])
			SPRC_MODE_STANDBY: begin
				mode_eff = crystal ? SPRC_MODE_STANDBY : SPRC_MODE_POWER_DN;
			end
			SPRC_MODE_EXT_STBY: begin
				mode_eff = crystal ? SPRC_MODE_EXT_STBY : SPRC_MODE_POWER_SV;
			end
			default: begin
				mode_eff = s.sleep_ctrl[SPRC_SM_MSB:SPRC_SM_LSB];
			end
		endcase
		mode_deep = (mode_eff != SPRC_MODE_IDLE) & (mode_eff != SPRC_MODE_NOISE_RED);
	end

	// Next-state logic for the whole block.
	always_comb begin
		next_s = s;
		next_s.vector_load = 1'b0;
		next_s.rdata = 8'h00;

		// Level synchronisers; only the second stage is read.
		next_s.por_sync = {s.por_sync[0], por_low_in};
		next_s.bod_sync = {s.bod_sync[0], bod_low_in};
		next_s.ext_sync = {s.ext_sync[0], ext_reset_n_in};

		// Pin low-time filter; short pulses are not counted as reset.
		if (~s.ext_sync[1] & ~reset_pin_disable_fuse_in) begin
			if (s.ext_low_cnt == SPRC_EXT_MIN_CYCLES - 7'h1) begin
				next_s.ext_trip = 1'b1;
			end else begin
				next_s.ext_low_cnt = s.ext_low_cnt + 7'h1;
			end
		end else begin
			next_s.ext_low_cnt = 7'h0;
			next_s.ext_trip = 1'b0;
		end

		// Unlock window counts down and closes by itself.
		if (s.unlock_bit) begin
			if (s.unlock_cnt == 3'h1) begin
				next_s.unlock_bit = 1'b0;
			end else begin
				next_s.unlock_cnt = s.unlock_cnt - 3'h1;
			end
		end

		// Off bit ages and clears itself.
		if (s.off_bit) begin
			if (s.off_age == SPRC_OFF_LAST_AGE) begin
				next_s.off_bit = 1'b0;
			end else begin
				next_s.off_age = s.off_age + 2'h1;
			end
		end

		// Register writes.
		if (wr_in) begin
			unique case (addr_in)
				SPRC_SLEEP_CTRL_ADDR: begin
					next_s.sleep_ctrl = wdata_in[3:0];
				end
				SPRC_POWER_RED_ADDR: begin
					next_s.power_red = wdata_in & SPRC_POWER_RED_MASK;
				end
				SPRC_CORE_CTRL_ADDR: begin
					if (wdata_in[SPRC_OFF_BIT] & wdata_in[SPRC_UNLOCK_BIT]) begin
						next_s.unlock_bit = 1'b1;
						next_s.unlock_cnt = SPRC_UNLOCK_CYCLES;
					end else if (wdata_in[SPRC_OFF_BIT] & s.unlock_bit) begin
						next_s.off_bit = 1'b1;
						next_s.off_age = 2'h0;
						next_s.unlock_bit = 1'b0;
					end else if (~wdata_in[SPRC_OFF_BIT]) begin
						next_s.off_bit = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// Register reads; data stands in the next cycle only.
		if (rd_in) begin
			unique case (addr_in)
				SPRC_SLEEP_CTRL_ADDR: next_s.rdata = {4'h0, s.sleep_ctrl};
				SPRC_POWER_RED_ADDR:  next_s.rdata = s.power_red;
				SPRC_CORE_CTRL_ADDR: begin
					next_s.rdata = {1'b0, s.off_bit, s.unlock_bit, 5'h00};
				end
				default: next_s.rdata = 8'h00;
			endcase
		end

		// Sleep entry and wake-up.
		unique case (s.sleep_st)
			SPRC_AWAKE: begin
				// Gate bit and a legal mode are both needed.
				if (sleep_instr_in & s.sleep_ctrl[SPRC_SE_BIT] & ~mode_rsvd) begin
					next_s.sleep_st = SPRC_ASLEEP;
					next_s.sleep_mode = mode_eff;
					next_s.bod_off = off_active & mode_deep;
					next_s.osc_keep = crystal & mode_eff[2];
				end
			end
			SPRC_ASLEEP: begin
				if (wake_in) begin
					next_s.sleep_st = SPRC_AWAKE;
					next_s.bod_off = 1'b0;
					next_s.osc_keep = 1'b0;
				end
			end
			default: begin
				next_s.sleep_st = SPRC_AWAKE;
			end
		endcase

		// Reset sequencer.
		unique case (s.rst_st)
			SPRC_RST_HOLD: begin
				if (~src_sync) begin
					next_s.rst_st = SPRC_RST_COUNT;
					next_s.tout_cnt = tout_sel;
				end
			end
			SPRC_RST_COUNT: begin
				if (src_sync) begin
					next_s.rst_st = SPRC_RST_HOLD;
				end else if (s.tout_cnt == 22'h0) begin
					next_s.rst_st = SPRC_RST_RUN;
					next_s.vector_load = 1'b1;
				end else begin
					next_s.tout_cnt = s.tout_cnt - 22'h1;
				end
			end
			SPRC_RST_RUN: begin
				if (src_sync) begin
					next_s.rst_st = SPRC_RST_HOLD;
				end
			end
			default: begin
				next_s.rst_st = SPRC_RST_HOLD;
			end
		endcase

		// Registers take their initial values while reset is held.
		if (s.rst_st != SPRC_RST_RUN) begin
			next_s.sleep_ctrl = SPRC_SLEEP_CTRL_RESET;
			next_s.power_red = SPRC_POWER_RED_RESET;
			next_s.off_bit = 1'b0;
			next_s.unlock_bit = 1'b0;
			next_s.sleep_st = SPRC_AWAKE;
			next_s.bod_off = 1'b0;
			next_s.osc_keep = 1'b0;
		end

		if (srst_in) begin
			next_s = SPRC_INIT;
		end
	end

	// State register.
	always_ff @(posedge clk_in) begin
		s <= next_s;
	end

	// Outputs.
	always_comb begin
		rdata_out = s.rdata;
		sleep_active_out = (s.sleep_st == SPRC_ASLEEP);
		sleep_mode_out = s.sleep_mode;
		bod_sleep_off_out = s.bod_off;
		osc_keep_out = s.osc_keep;
		periph_clk_enable_out = ~stop_eff;
		periph_io_block_out = stop_eff;
		comparator_mux_allow_out = ~stop_eff[SPRC_CONV_BIT];
		port_reset_out = src_raw;
		core_reset_out = src_raw | (s.rst_st != SPRC_RST_RUN);
		vector_load_out = s.vector_load;
	end

endmodule : sprc_ctrl

`default_nettype wire

// ### sprc_pkg.sv
// Constants, field layouts and enumerations for the sleep, power reduction
// and reset control block.
// Assumes a 40 MHz system clock and an 8-bit register port.
`default_nettype none

package sprc_pkg;

	// Register addresses on the plain register port.
	localparam logic [7:0] SPRC_SLEEP_CTRL_ADDR = 8'h33; // Sleep mode control.
	localparam logic [7:0] SPRC_POWER_RED_ADDR  = 8'h64; // Power reduction.
	localparam logic [7:0] SPRC_CORE_CTRL_ADDR  = 8'h35; // Core control.

	// Reset values.
	localparam logic [3:0] SPRC_SLEEP_CTRL_RESET = 4'h0; // Sleep control bits 3:0.
	localparam logic [7:0] SPRC_POWER_RED_RESET  = 8'h00; // All clocks running.

	// Sleep mode control fields.
	localparam int SPRC_SE_BIT = 0; // Sleep gate bit position.
	localparam int SPRC_SM_LSB = 1; // Mode select low bit.
	localparam int SPRC_SM_MSB = 3; // Mode select high bit.

	// Core control fields.
	localparam int SPRC_OFF_BIT    = 6; // Brownout sleep off bit.
	localparam int SPRC_UNLOCK_BIT = 5; // Brownout sleep unlock bit.

	// Power reduction fields.
	localparam int         SPRC_TWI_BIT   = 7; // Two-wire clock stop.
	localparam int         SPRC_TIM2_BIT  = 6; // Timer2 clock stop.
	localparam int         SPRC_TIM0_BIT  = 5; // Timer0 clock stop.
	localparam int         SPRC_TIM1_BIT  = 3; // Timer1 clock stop.
	localparam int         SPRC_SPI_BIT   = 2; // Serial peripheral clock stop.
	localparam int         SPRC_UART_BIT  = 1; // Serial port clock stop.
	localparam int         SPRC_CONV_BIT  = 0; // Converter clock stop.
	localparam logic [7:0] SPRC_POWER_RED_MASK = 8'hef; // Bit 4 unimplemented.

	// Sleep mode codes.
	typedef enum logic [2:0] {
		SPRC_MODE_IDLE      = 3'h0,
		SPRC_MODE_NOISE_RED = 3'h1,
		SPRC_MODE_POWER_DN  = 3'h2,
		SPRC_MODE_POWER_SV  = 3'h3,
		SPRC_MODE_RSVD_A    = 3'h4,
		SPRC_MODE_RSVD_B    = 3'h5,
		SPRC_MODE_STANDBY   = 3'h6,
		SPRC_MODE_EXT_STBY  = 3'h7
	} sprc_mode_t;

	// Sleep state machine, one-hot.
	typedef enum logic [1:0] {
		SPRC_AWAKE  = 2'b01,
		SPRC_ASLEEP = 2'b10
	} sprc_sleep_t;

	// Reset sequencer, one-hot.
	typedef enum logic [2:0] {
		SPRC_RST_HOLD  = 3'b001,
		SPRC_RST_COUNT = 3'b010,
		SPRC_RST_RUN   = 3'b100
	} sprc_rst_t;

	// Timing.
	localparam int         SPRC_CLK_MHZ       = 40;   // System clock rate.
	localparam int         SPRC_CLK_PERIOD_NS = 25;   // System clock period.
	localparam logic [2:0] SPRC_UNLOCK_CYCLES = 3'h4; // Unlock window length.
	localparam logic [1:0] SPRC_OFF_LAST_AGE  = 2'h2; // Off bit clears after this age.
	localparam logic [1:0] SPRC_OFF_ACTIVE_AGE = 2'h2; // Off bit effective at this age.
	localparam int         SPRC_EXT_MIN_NS    = 2500; // Least low time on the pin.
	localparam logic [6:0] SPRC_EXT_MIN_CYCLES =
		7'((SPRC_EXT_MIN_NS + SPRC_CLK_PERIOD_NS - 1) / SPRC_CLK_PERIOD_NS);
	localparam logic [21:0] SPRC_TOUT_SHORT_CYCLES = 22'h6; // Short time-out.
	localparam int         SPRC_TOUT_MID_US   = 4100;  // Middle time-out.
	localparam int         SPRC_TOUT_LONG_US  = 65000; // Long time-out.

endpackage : sprc_pkg

`default_nettype wire

// ### sprc_ctrl_chk.sv
// Checker for the sleep, power reduction and reset control block.
// Assumes it is bound to sprc_ctrl and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module sprc_chk
	import sprc_pkg::*;
(
	input wire logic       clk_in,
	input wire logic       srst_in,
	input wire logic [7:0] addr_in,
	input wire logic       rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic       sleep_instr_in,
	input wire logic       sleep_active_out,
	input wire logic [2:0] sleep_mode_out,
	input wire logic       bod_sleep_off_out,
	input wire logic       osc_keep_out,
	input wire logic [3:0] clock_select_fuse_in,
	input wire logic       timer2_async_select_in,
	input wire logic [7:0] periph_clk_enable_out,
	input wire logic [7:0] periph_io_block_out,
	input wire logic       comparator_mux_allow_out,
	input wire logic       por_low_in,
	input wire logic       port_reset_out,
	input wire logic       core_reset_out,
	input wire logic       vector_load_out
);
	// Every check runs on the system clock and rests during reset.
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	// The start pulse lasts exactly one cycle.
	sequence one_pulse; vector_load_out ##1 !vector_load_out; endsequence
	sleep_hi_a: assert property (rd_in && addr_in == SPRC_SLEEP_CTRL_ADDR
		|=> rdata_out[7:4] == 4'h0) else $error("sleep control high bits set");
	prr_bit4_a: assert property (rd_in && addr_in == SPRC_POWER_RED_ADDR
		|=> !rdata_out[4]) else $error("power reduction bit 4 set");
	clk_gate_a: assert property (periph_clk_enable_out == ~periph_io_block_out
		&& periph_clk_enable_out[4]) else $error("clock enables disagree");
	t2_async_a: assert property (timer2_async_select_in
		|-> !periph_io_block_out[SPRC_TIM2_BIT]) else $error("timer2 stopped");
	conv_mux_a: assert property (comparator_mux_allow_out
		== !periph_io_block_out[SPRC_CONV_BIT]) else $error("mux allow wrong");
	por_now_a: assert property (por_low_in
		|-> port_reset_out && core_reset_out) else $error("supply reset late");
	sleep_cause_a: assert property ($rose(sleep_active_out)
		|-> $past(sleep_instr_in)) else $error("sleep without instruction");
	mode_legal_a: assert property ($rose(sleep_active_out)
		|-> !(sleep_mode_out inside {3'h4, 3'h5})) else $error("reserved mode slept");
	bod_off_a: assert property (bod_sleep_off_out
		|-> sleep_active_out && sleep_mode_out[2:1] != 2'b00) else $error("detector off");
	osc_keep_a: assert property (osc_keep_out |-> sleep_active_out
		&& clock_select_fuse_in[3] && sleep_mode_out[2:1] == 2'b11) else $error("osc kept");
	vec_pulse_a: assert property (vector_load_out |-> one_pulse)
		else $error("start pulse too long");
	vec_hold_a: assert property (vector_load_out |-> $past(core_reset_out, 6))
		else $error("reset not stretched");
endmodule : sprc_chk
bind sprc_ctrl sprc_chk u_chk (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
	.rd_in(rd_in), .rdata_out(rdata_out), .sleep_instr_in(sleep_instr_in),
	.sleep_active_out(sleep_active_out), .sleep_mode_out(sleep_mode_out),
	.bod_sleep_off_out(bod_sleep_off_out), .osc_keep_out(osc_keep_out),
	.clock_select_fuse_in(clock_select_fuse_in),
	.timer2_async_select_in(timer2_async_select_in),
	.periph_clk_enable_out(periph_clk_enable_out), .periph_io_block_out(periph_io_block_out),
	.comparator_mux_allow_out(comparator_mux_allow_out), .por_low_in(por_low_in),
	.port_reset_out(port_reset_out), .core_reset_out(core_reset_out),
	.vector_load_out(vector_load_out));
`default_nettype wire

// ### sprc_tb.sv
// Self-checking bench for the sleep, power reduction and reset control block.
// Assumes the checker binds itself; the short start-up fuse setting is used.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin #1; n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD %0t %s", $time, m); end end
module testbench;
	import sprc_pkg::*;
	logic       clk_in = 1'b0, srst_in = 1'b1;          // Clock and reset.
	logic [7:0] addr_in = 8'h00, wdata_in = 8'h00;      // Register port.
	logic       wr_in = 1'b0, rd_in = 1'b0;             // Register strobes.
	logic       sleep_instr_in = 1'b0, wake_in = 1'b0;  // Core pulses.
	logic       timer2_async_select_in = 1'b0;          // Timer2 clocking.
	logic [3:0] clock_select_fuse_in = 4'h8;            // Crystal selected.
	logic       reset_pin_disable_fuse_in = 1'b0, bod_enable_fuse_in = 1'b0;
	logic       por_low_in = 1'b0, ext_reset_n_in = 1'b1;  // Reset sources.
	logic       wdt_reset_in = 1'b0, bod_low_in = 1'b0;
	logic [7:0] rdata_out, periph_clk_enable_out, periph_io_block_out;
	logic [2:0] sleep_mode_out;                         // Mode entered.
	logic       sleep_active_out, bod_sleep_off_out, osc_keep_out;
	logic       comparator_mux_allow_out, port_reset_out, core_reset_out, vector_load_out;
	int         miscompares = 0, n_tests = 0;           // Run counters.

	// Short time-outs keep the run brief.
	sprc_ctrl #(.TOUT_MID_CYCLES(20), .TOUT_LONG_CYCLES(40)) u_dut (.clk_in(clk_in),
		.srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .sleep_instr_in(sleep_instr_in),
		.wake_in(wake_in), .timer2_async_select_in(timer2_async_select_in),
		.clock_select_fuse_in(clock_select_fuse_in), .startup_time_fuse_in(2'b00),
		.reset_pin_disable_fuse_in(reset_pin_disable_fuse_in),
		.bod_enable_fuse_in(bod_enable_fuse_in), .por_low_in(por_low_in),
		.ext_reset_n_in(ext_reset_n_in), .wdt_reset_in(wdt_reset_in),
		.bod_low_in(bod_low_in), .sleep_active_out(sleep_active_out),
		.sleep_mode_out(sleep_mode_out), .bod_sleep_off_out(bod_sleep_off_out),
		.osc_keep_out(osc_keep_out), .periph_clk_enable_out(periph_clk_enable_out),
		.periph_io_block_out(periph_io_block_out),
		.comparator_mux_allow_out(comparator_mux_allow_out),
		.port_reset_out(port_reset_out), .core_reset_out(core_reset_out),
		.vector_load_out(vector_load_out));

	// The clock toggles every half period of 12.5 ns.
	always #12.5 clk_in = ~clk_in;

	// One bus and core cycle, driven at the rising edge.
	task automatic cyc(input logic w, r, s, k, input logic [7:0] a, d);
		@(posedge clk_in);
		wr_in <= w;
		rd_in <= r;
		sleep_instr_in <= s;
		wake_in <= k;
		addr_in <= a;
		wdata_in <= d;
	endtask : cyc

	// An empty cycle.
	task automatic idle;
		cyc(0, 0, 0, 0, 8'h00, 8'h00);
	endtask : idle

	// A register write.
	task automatic wr(input logic [7:0] a, d);
		cyc(1, 0, 0, 0, a, d);
	endtask : wr

	// A register read; the data are checked in the cycle after the strobe.
	task automatic rd(input logic [7:0] a, e);
		cyc(0, 1, 0, 0, a, 8'h00);
		idle;
		`CHK(rdata_out, e, "read data")
	endtask : rd

	// Waits, bounded, for the start pulse and returns the cycles it took.
	task automatic wait_vec(output int n);
		for (n = 0; n < 300 && vector_load_out !== 1'b1; n++) begin
			idle;
			#1;
		end
		`CHK(vector_load_out, 1'b1, "core start")
	endtask : wait_vec

	// Prints the counts and the verdict, then stops.
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	// Cuts a hang short.
	initial begin
		#(25 * 5000);
		miscompares++;
		wrap_up();
	end

	// Main sequence.
	initial begin
		int n;
		logic [2:0] em;
		repeat (6) @(posedge clk_in);
		srst_in <= 1'b0;
		wait_vec(n);
		rd(SPRC_SLEEP_CTRL_ADDR, 8'h00);
		rd(SPRC_POWER_RED_ADDR, 8'h00);
		rd(SPRC_CORE_CTRL_ADDR, 8'h00);
		rd(8'h00, 8'h00);
		wr(SPRC_SLEEP_CTRL_ADDR, 8'hff);
		rd(SPRC_SLEEP_CTRL_ADDR, 8'h0f);
		wr(SPRC_POWER_RED_ADDR, 8'hff);
		rd(SPRC_POWER_RED_ADDR, 8'hef);
		`CHK(periph_io_block_out, 8'hef, "stops")
		`CHK(periph_clk_enable_out, 8'h10, "enables")
		`CHK(comparator_mux_allow_out, 1'b0, "mux")
		timer2_async_select_in <= 1'b1;
		idle;
		`CHK(periph_io_block_out, 8'haf, "timer2 async")
		timer2_async_select_in <= 1'b0;
		wr(SPRC_POWER_RED_ADDR, 8'h00);
		idle;
		`CHK(periph_clk_enable_out, 8'hff, "all running")
		$display("test registers done");
		// Every mode code, with and without a crystal.
		for (int x = 0; x < 2; x++) begin
			for (int m = 0; m < 8; m++) begin
				em = (x == 0 && m[2:1] == 2'b11) ? {2'b01, m[0]} : 3'(m);
				clock_select_fuse_in <= (x == 1) ? 4'h8 : 4'h1;
				wr(SPRC_SLEEP_CTRL_ADDR, {4'h0, 3'(m), 1'b1});
				cyc(0, 0, 1, 0, 8'h00, 8'h00);
				idle;
				`CHK(sleep_active_out, 1'(m != 4 && m != 5), "sleep")
				if (m != 4 && m != 5) begin
					`CHK(sleep_mode_out, em, "mode")
					`CHK(osc_keep_out, 1'(x == 1 && m > 5), "osc")
					cyc(0, 0, 0, 1, 8'h00, 8'h00);
					idle;
					`CHK(sleep_active_out, 1'b0, "wake")
				end
			end
		end
		wr(SPRC_SLEEP_CTRL_ADDR, 8'h04);
		cyc(0, 0, 1, 0, 8'h00, 8'h00);
		idle;
		`CHK(sleep_active_out, 1'b0, "gate closed")
		$display("test sleep done");
		// Sleep one cycle early, on time, late, and with no unlock at all.
		wr(SPRC_SLEEP_CTRL_ADDR, 8'h05);
		for (int i = 0; i < 4; i++) begin
			if (i < 3) wr(SPRC_CORE_CTRL_ADDR, 8'h60);
			wr(SPRC_CORE_CTRL_ADDR, 8'h40);
			repeat ((i == 3) ? 2 : i + 1) idle;
			cyc(0, 0, 1, 0, 8'h00, 8'h00);
			idle;
			`CHK(bod_sleep_off_out, 1'(i == 1), "detector off")
			cyc(0, 0, 0, 1, 8'h00, 8'h00);
			repeat (4) idle;
		end
		$display("test unlock done");
		wdt_reset_in <= 1'b1;
		`CHK(port_reset_out, 1'b1, "watchdog")
		idle;
		wdt_reset_in <= 1'b0;
		wait_vec(n);
		wr(SPRC_POWER_RED_ADDR, 8'h01);
		idle;
		por_low_in <= 1'b1;
		`CHK(port_reset_out & core_reset_out, 1'b1, "supply")
		repeat (3) idle;
		por_low_in <= 1'b0;
		wait_vec(n);
		`CHK(1'(n >= 6), 1'b1, "time-out")
		rd(SPRC_POWER_RED_ADDR, 8'h00);
		bod_low_in <= 1'b1;
		`CHK(port_reset_out, 1'b0, "detector unfused")
		bod_enable_fuse_in <= 1'b1;
		`CHK(port_reset_out, 1'b1, "detector")
		idle;
		bod_low_in <= 1'b0;
		wait_vec(n);
		reset_pin_disable_fuse_in <= 1'b1;
		ext_reset_n_in <= 1'b0;
		`CHK(port_reset_out, 1'b0, "pin ignored")
		repeat (120) idle;
		`CHK(core_reset_out, 1'b0, "pin ignored long")
		reset_pin_disable_fuse_in <= 1'b0;
		`CHK(port_reset_out, 1'b1, "pin")
		repeat (110) idle;
		ext_reset_n_in <= 1'b1;
		wait_vec(n);
		$display("test resets done");
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
